//--- design/mac_accumulator_control_regs.sv
// Purpose: accumulator, status, control and repeat registers of the MAC
// Assumes: one 25 MHz clock; SFR and store requests synchronous to it
// Notes: datapath, repeat sequencer and trap logic sit outside this bank
//
// Contract
// - accumulator is 40 bits: ext byte, high word 31..16, low word
// - low word holds bits 15..0, read and written as 16 bits
// - status low byte is extension bits 39..32, software read/write
// - negative flag set from result sign at op completion
// - zero flag set when accumulator is zero at op completion
// - carry flag set on carry or borrow out of an op
// - sticky overflow flag set on 40-bit overflow, held until cleared
// - extension flag set when extension holds significant bits
// - sticky limit flag on saturation or min/max change, held
// - status bit 15 flags a coprocessor interrupt request, not settable
// - flags change on coprocessor ops and status writes, never on accumulator moves
// - saturation mode clamps op results to 32 bits
// - product shift mode shifts signed-by-signed products left once
// - each of carry/overflow/extension/limit interrupts only when masked in
// - global enable zero blocks new coprocessor requests; a bit already pending stays on the output
// - repeat word holds 13-bit count, executions minus one
// - repeat flag set while a repeated instruction runs
// - byte write clears the other byte of the same register
// - unimplemented bits ignore writes and read zero
// - store codes: status 0, high 1, limited 2, low 4, ctrl 5, rep 6
// - store reads see current values without pipeline hazard
// - limited code returns saturated high word; low and status raw
`timescale 1ns/1ps
`default_nettype none
module mac_accumulator_control_regs
    import mac_regs_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire sfr_req_type sfr_req_in,
    output logic [15:0] sfr_rdata_out,
    input wire logic cost_valid_in,
    input wire logic [4:0] cost_code_in,
    output logic [15:0] cost_data_out,
    input wire op_event_type op_in,
    input wire logic [31:0] prod_in,
    input wire logic prod_signed_in,
    output logic [31:0] prod_out,
    input wire logic rep_load_in,
    input wire logic [12:0] rep_count_in,
    input wire logic rep_step_in,
    input wire logic rep_end_in,
    output logic [39:0] acc_out,
    output logic saturate_enable_out,
    output logic product_shift_enable_out,
    output logic coproc_irq_out,
    output logic [12:0] repeat_count_out,
    output logic repeat_active_out
);

    logic [15:0] acc_low;
    logic [15:0] acc_high;
    logic [7:0] acc_ext;
    status_flags_type flags;
    logic [15:0] control;
    logic [RW_CNT_W-1:0] rep_count;
    logic rep_flag;
    logic irq_req_q;
    logic [15:0] next_low;
    logic [15:0] next_high;
    logic [7:0] next_ext;
    status_flags_type next_flags;
    logic [15:0] next_control;
    logic [RW_CNT_W-1:0] next_count;
    logic next_rflag;
    logic wr_low;
    logic wr_high;
    logic wr_status;
    logic wr_control;
    logic wr_repeat;
    logic [15:0] status_word;
    logic [15:0] st_w;
    logic [15:0] repeat_word;
    logic irq_req;
    logic irq_rise;
    logic [39:0] fu_result;
    status_flags_type fu_flags;
    logic [15:0] rep_w;
    logic [15:0] store_data;
    assign wr_low = sfr_hit(sfr_req_in, ADDR_ACC_LOW);
    assign wr_high = sfr_hit(sfr_req_in, ADDR_ACC_HIGH);
    assign wr_status = sfr_hit(sfr_req_in, ADDR_STATUS);
    assign wr_control = sfr_hit(sfr_req_in, ADDR_CONTROL);
    assign wr_repeat = sfr_hit(sfr_req_in, ADDR_REPEAT);
    assign status_word = pack_status(flags, acc_ext);
    assign repeat_word = {rep_flag, 2'b00, rep_count};
    // byte writes clear the other lane; unimplemented bits dropped
    assign st_w = apply_write(status_word, sfr_req_in.wdata,
        sfr_req_in.be) & STATUS_IMPL;

    mac_flag_unit u_flags (
        .op_in(op_in),
        .sat_en_in(control[CW_MS]),
        .result_out(fu_result),
        .flags_out(fu_flags)
    );

    // an op finishing in the same cycle as a move wins the accumulator
    always_comb
    begin
        next_low = acc_low;
        next_high = acc_high;
        next_ext = acc_ext;
        if (op_in.done)
            {next_ext, next_high, next_low} = fu_result;
        else
        begin
            if (wr_low)
                next_low = apply_write(acc_low, sfr_req_in.wdata,
                    sfr_req_in.be);
            if (wr_high)
                next_high = apply_write(acc_high, sfr_req_in.wdata,
                    sfr_req_in.be);
            if (wr_status)
                next_ext = st_w[ST_EXT_MSB:ST_EXT_LSB];
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            acc_low <= WORD_ZERO;
            acc_high <= WORD_ZERO;
            acc_ext <= STATUS_RESET[ST_EXT_MSB:ST_EXT_LSB];
        end
        else
        begin
            acc_low <= next_low;
            acc_high <= next_high;
            acc_ext <= next_ext;
        end
    end

    // edge of the masked request raises the pending bit once
    assign irq_req = control[CW_GIE] && ((flags.carry && control[CW_CM])
        || (flags.ovf && control[CW_VM]) || (flags.ext && control[CW_EM])
        || (flags.limit && control[CW_LM]));
    assign irq_rise = irq_req && !irq_req_q;

    always_comb
    begin
        next_flags = flags;
        if (wr_status)
        begin
            next_flags.neg = st_w[ST_NEG];
            next_flags.zero = st_w[ST_ZERO];
            next_flags.carry = st_w[ST_CARRY];
            next_flags.ovf = st_w[ST_OVF];
            next_flags.ext = st_w[ST_EXT];
            next_flags.limit = st_w[ST_LIMIT];
            // software may only clear the request bit, never set it
            if (!st_w[ST_IRQ])
                next_flags.irq = 1'b0;
        end
        // plain moves never reach here, only completed ops
        if (op_in.done)
        begin
            next_flags.neg = fu_flags.neg;
            next_flags.zero = fu_flags.zero;
            next_flags.carry = fu_flags.carry;
            next_flags.ext = fu_flags.ext;
            // sticky bits: a set in the clearing cycle still wins
            next_flags.ovf = next_flags.ovf || fu_flags.ovf;
            next_flags.limit = next_flags.limit || fu_flags.limit;
        end
        if (irq_rise)
            next_flags.irq = 1'b1;
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            flags <= status_flags_type'({STATUS_RESET[ST_IRQ],
                STATUS_RESET[ST_LIMIT:ST_NEG]});
            irq_req_q <= 1'b0;
        end
        else
        begin
            flags <= next_flags;
            irq_req_q <= irq_req;
        end
    end

    always_comb
    begin
        next_control = control;
        if (wr_control)
            next_control = apply_write(control, sfr_req_in.wdata,
                sfr_req_in.be) & CONTROL_IMPL;
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            control <= CONTROL_RESET;
        else
            control <= next_control;
    end

    // the sequencer's own load and end outrank a software write
    always_comb
    begin
        next_count = rep_count;
        next_rflag = rep_flag;
        if (wr_repeat)
        begin
            next_count = rep_w[RW_CNT_W-1:0];
            next_rflag = rep_w[RW_FLAG];
        end
        if (rep_step_in)
            next_count = rep_count - RW_CNT_ONE;
        if (rep_load_in)
        begin
            next_count = rep_count_in;
            next_rflag = 1'b1;
        end
        else if (rep_end_in)
            next_rflag = 1'b0;
    end

    assign rep_w = apply_write(repeat_word, sfr_req_in.wdata,
        sfr_req_in.be) & REPEAT_IMPL;

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rep_count <= REPEAT_RESET[RW_CNT_W-1:0];
            rep_flag <= REPEAT_RESET[RW_FLAG];
        end
        else
        begin
            rep_count <= next_count;
            rep_flag <= next_rflag;
        end
    end

    // store reads the post-update values, so no stall is ever needed
    mac_coreg_read_mux u_store_mux (
        .code_in(cost_code_in),
        .status_in(pack_status(next_flags, next_ext)),
        .high_in(next_high),
        .low_in(next_low),
        .ext_in(next_ext),
        .control_in(next_control),
        .repeat_in({next_rflag, 2'b00, next_count}),
        .data_out(store_data)
    );

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            cost_data_out <= WORD_ZERO;
        else if (cost_valid_in)
            cost_data_out <= store_data;
    end

    // plain SFR reads see the stored value, the pipeline-exposed path
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            sfr_rdata_out <= WORD_ZERO;
        else if (sfr_req_in.rd)
            case (sfr_req_in.addr)
                ADDR_ACC_LOW: sfr_rdata_out <= acc_low;
                ADDR_ACC_HIGH: sfr_rdata_out <= acc_high;
                ADDR_STATUS: sfr_rdata_out <= status_word;
                ADDR_CONTROL: sfr_rdata_out <= control;
                ADDR_REPEAT: sfr_rdata_out <= repeat_word;
                default: sfr_rdata_out <= WORD_ZERO;
            endcase
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            prod_out <= 32'h00000000;
        else if (control[CW_MP] && prod_signed_in)
            prod_out <= {prod_in[30:0], 1'b0};
        else
            prod_out <= prod_in;
    end

    assign acc_out = {acc_ext, acc_high, acc_low};
    assign saturate_enable_out = control[CW_MS];
    assign product_shift_enable_out = control[CW_MP];
    assign coproc_irq_out = flags.irq;
    assign repeat_count_out = rep_count;
    assign repeat_active_out = rep_flag;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);
    acc_load_a: assert property (op_in.done |=>
        acc_out == $past(fu_result)) else $error("op result not loaded");
    low_write_a: assert property (wr_low && !op_in.done &&
        sfr_req_in.be == BE_WORD |=> acc_low == $past(sfr_req_in.wdata))
        else $error("low word write lost");
    ext_write_a: assert property (wr_status && !op_in.done &&
        sfr_req_in.be == BE_LOW |=> acc_ext == $past(sfr_req_in.wdata[7:0]))
        else $error("extension write lost");
    neg_zero_a: assert property (op_in.done |=>
        flags.neg == acc_out[39] && flags.zero == !(|acc_out))
        else $error("negative or zero flag wrong");
    carry_flag_a: assert property (op_in.done |=>
        flags.carry == $past(op_in.carry)) else $error("carry flag wrong");
    sticky_ovf_a: assert property (flags.ovf && !wr_status |=>
        flags.ovf) else $error("overflow flag dropped");
    flags_hold_a: assert property (!op_in.done && !wr_status |=>
        $stable({flags.neg, flags.zero, flags.carry, flags.ext}))
        else $error("flags changed without op");
    sat_range_a: assert property (op_in.done && control[CW_MS] |=>
        !needs_sat(acc_out) && !flags.ext) else $error("result not saturated");
    limit_set_a: assert property (op_in.done && op_in.minmax_changed
        |=> flags.limit) else $error("limit flag not set");
    irq_mask_a: assert property (!irq_req_q && control[CW_GIE] &&
        flags.carry && control[CW_CM] |=> flags.irq ##1 coproc_irq_out)
        else $error("masked request not raised");
    irq_global_a: assert property (!control[CW_GIE] && !flags.irq
        |=> !flags.irq) else $error("request raised while disabled");
    prod_shift_a: assert property (control[CW_MP] && prod_signed_in
        |=> prod_out == {$past(prod_in[30:0]), 1'b0})
        else $error("product not shifted");
    rep_flag_a: assert property (rep_load_in |=> repeat_active_out &&
        repeat_count_out == $past(rep_count_in)) else $error("repeat load");
    byte_clear_a: assert property (wr_high && !op_in.done &&
        sfr_req_in.be == BE_LOW |=> acc_high[15:8] == BYTE_ZERO)
        else $error("other byte not cleared");
    unimpl_zero_a: assert property (sfr_req_in.rd &&
        sfr_req_in.addr == ADDR_CONTROL |=> (sfr_rdata_out & ~CONTROL_IMPL)
        == WORD_ZERO) else $error("unimplemented bits read nonzero");
    store_low_a: assert property (cost_valid_in &&
        cost_code_in == CODE_LOW |=> cost_data_out == acc_low)
        else $error("store read of low word stale");

endmodule
`default_nettype wire

//--- design/mac_regs_pkg.sv
// Purpose: constants, carriers and helpers for the accumulator register bank
// Assumes: 16-bit special-function-register bus, byte enables per lane
// Notes: shared by the bank, its flag unit and its store-read selector
`default_nettype none
package mac_regs_pkg;

    localparam logic [15:0] ADDR_ACC_LOW = 16'hFE5C;
    localparam logic [15:0] ADDR_ACC_HIGH = 16'hFE5E;
    localparam logic [15:0] ADDR_REPEAT = 16'hFFDA;
    localparam logic [15:0] ADDR_CONTROL = 16'hFFDC;
    localparam logic [15:0] ADDR_STATUS = 16'hFFDE;

    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] STATUS_RESET = 16'h0200;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] REPEAT_RESET = 16'h0000;

    // status word fields
    localparam int ST_IRQ = 15;
    localparam int ST_LIMIT = 13;
    localparam int ST_EXT = 12;
    localparam int ST_OVF = 11;
    localparam int ST_CARRY = 10;
    localparam int ST_ZERO = 9;
    localparam int ST_NEG = 8;
    localparam int ST_EXT_MSB = 7;
    localparam int ST_EXT_LSB = 0;

    // control word fields
    localparam int CW_GIE = 15;
    localparam int CW_LM = 14;
    localparam int CW_EM = 13;
    localparam int CW_VM = 12;
    localparam int CW_CM = 11;
    localparam int CW_MP = 10;
    localparam int CW_MS = 9;

    // repeat word fields
    localparam int RW_FLAG = 15;
    localparam int RW_CNT_W = 13;
    localparam logic [RW_CNT_W-1:0] RW_CNT_ONE = 13'h0001;

    // implemented bits; the rest read zero
    localparam logic [15:0] STATUS_IMPL = 16'hBFFF;
    localparam logic [15:0] CONTROL_IMPL = 16'hFE00;
    localparam logic [15:0] REPEAT_IMPL = 16'h9FFF;

    localparam logic [4:0] CODE_STATUS = 5'h00;
    localparam logic [4:0] CODE_HIGH = 5'h01;
    localparam logic [4:0] CODE_LIMITED = 5'h02;
    localparam logic [4:0] CODE_LOW = 5'h04;
    localparam logic [4:0] CODE_CONTROL = 5'h05;
    localparam logic [4:0] CODE_REPEAT = 5'h06;

    localparam logic [1:0] BE_LOW = 2'h1;
    localparam logic [1:0] BE_HIGH = 2'h2;
    localparam logic [1:0] BE_WORD = 2'h3;

    localparam logic [39:0] SAT_MAX = 40'h007FFFFFFF;
    localparam logic [39:0] SAT_MIN = 40'hFF80000000;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [1:0] be;
        logic [15:0] addr;
        logic [15:0] wdata;
    } sfr_req_type;

    typedef struct packed {
        logic done;
        logic [39:0] result;
        logic carry;
        logic overflow;
        logic minmax_changed;
    } op_event_type;

    typedef struct packed {
        logic irq;
        logic limit;
        logic ext;
        logic ovf;
        logic carry;
        logic zero;
        logic neg;
    } status_flags_type;

    function automatic logic [15:0] apply_write(input logic [15:0] old,
        input logic [15:0] wdata, input logic [1:0] be);
        case (be)
            BE_WORD: apply_write = wdata;
            BE_LOW: apply_write = {BYTE_ZERO, wdata[7:0]};
            BE_HIGH: apply_write = {wdata[15:8], BYTE_ZERO};
            default: apply_write = old;
        endcase
    endfunction

    function automatic logic sfr_hit(input sfr_req_type req,
        input logic [15:0] addr);
        sfr_hit = req.wr && (req.addr == addr);
    endfunction

    function automatic logic needs_sat(input logic [39:0] v);
        needs_sat = !((&v[39:31]) || !(|v[39:31]));
    endfunction

    function automatic logic [39:0] sat32(input logic [39:0] v);
        if (!needs_sat(v))
            sat32 = v;
        else if (v[39])
            sat32 = SAT_MIN;
        else
            sat32 = SAT_MAX;
    endfunction

    function automatic logic [15:0] pack_status(input status_flags_type f,
        input logic [7:0] ext);
        pack_status = {f.irq, 1'b0, f.limit, f.ext, f.ovf, f.carry,
            f.zero, f.neg, ext};
    endfunction

endpackage
`default_nettype wire

//--- design/mac_flag_unit.sv
// Purpose: condition flags and saturation of a finished coprocessor result
// Assumes: result, carry and overflow come from the datapath with op done
// Notes: purely combinational; the bank registers what it returns
`timescale 1ns/1ps
`default_nettype none
module mac_flag_unit
    import mac_regs_pkg::*;
(
    input wire op_event_type op_in,
    input wire logic sat_en_in,
    output logic [39:0] result_out,
    output status_flags_type flags_out
);

    logic sat_hit;

    always_comb
    begin
        sat_hit = sat_en_in && needs_sat(op_in.result);
        result_out = sat_hit ? sat32(op_in.result) : op_in.result;
        flags_out.irq = 1'b0;
        flags_out.neg = result_out[39];
        flags_out.zero = ~|result_out;
        flags_out.carry = op_in.carry;
        flags_out.ovf = op_in.overflow;
        // significant extension: top nine bits are not one sign copy
        flags_out.ext = needs_sat(result_out);
        flags_out.limit = sat_hit || op_in.minmax_changed;
    end

endmodule
`default_nettype wire

//--- design/mac_coreg_read_mux.sv
// Purpose: register selection for the coprocessor store by 5-bit code
// Assumes: inputs are the values the bank will hold after this cycle
// Notes: unknown codes return zero
`timescale 1ns/1ps
`default_nettype none
module mac_coreg_read_mux
    import mac_regs_pkg::*;
(
    input wire logic [4:0] code_in,
    input wire logic [15:0] status_in,
    input wire logic [15:0] high_in,
    input wire logic [15:0] low_in,
    input wire logic [7:0] ext_in,
    input wire logic [15:0] control_in,
    input wire logic [15:0] repeat_in,
    output logic [15:0] data_out
);

    logic [39:0] limited;

    always_comb
    begin
        limited = sat32({ext_in, high_in, low_in});
        case (code_in)
            CODE_STATUS: data_out = status_in;
            CODE_HIGH: data_out = high_in;
            CODE_LIMITED: data_out = limited[31:16];
            CODE_LOW: data_out = low_in;
            CODE_CONTROL: data_out = control_in;
            CODE_REPEAT: data_out = repeat_in;
            default: data_out = WORD_ZERO;
        endcase
    end

endmodule
`default_nettype wire

//--- bench/mac_cpu_model.sv
// Purpose: cpu core side of the bank, issuing sfr and store requests
// Assumes: requests change at the falling edge, taken at the rising edge
// Notes: released address and data are inverted so stale values never match
`timescale 1ns/1ps
`default_nettype none
module mac_cpu_model
    import mac_regs_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic [15:0] sfr_rdata_in,
    input wire logic [15:0] cost_data_in,
    output sfr_req_type sfr_req_out,
    output logic cost_valid_out,
    output logic [4:0] cost_code_out
);
    initial
    begin
        sfr_req_out = '0;
        cost_valid_out = 1'b0;
        cost_code_out = 5'h1F;
    end
    task automatic sfr_wr(input logic [15:0] a, input logic [15:0] d,
        input logic [1:0] be);
        @(negedge clk_sys_in);
        sfr_req_out = '{rd: 1'b0, wr: 1'b1, be: be, addr: a, wdata: d};
        @(negedge clk_sys_in);
        sfr_req_out = '{rd: 1'b0, wr: 1'b0, be: ~be, addr: ~a, wdata: ~d};
    endtask
    task automatic sfr_rd(input logic [15:0] a, output logic [15:0] d);
        @(negedge clk_sys_in);
        sfr_req_out = '{rd: 1'b1, wr: 1'b0, be: BE_WORD, addr: a, wdata: 0};
        @(negedge clk_sys_in);
        sfr_req_out = '{rd: 1'b0, wr: 1'b0, be: 0, addr: ~a, wdata: 16'hFFFF};
        d = sfr_rdata_in;
    endtask
    task automatic co_rd(input logic [4:0] c, output logic [15:0] d);
        @(negedge clk_sys_in);
        cost_valid_out = 1'b1;
        cost_code_out = c;
        @(negedge clk_sys_in);
        cost_valid_out = 1'b0;
        cost_code_out = ~c;
        d = cost_data_in;
    endtask
endmodule
`default_nettype wire

//--- bench/mac_accumulator_control_regs_bench.sv
// Purpose: self-checking bench of the accumulator register bank
// Assumes: datapath and repeat pulses are driven here in the core's place
// Notes: expected values come from a plain register model kept below
`timescale 1ns/1ps
`default_nettype none
module mac_accumulator_control_regs_bench
    import mac_regs_pkg::*;
;
    logic clk_sys_in, nrst_in, cost_valid_in, prod_signed_in;
    logic rep_load_in, rep_step_in, rep_end_in;
    logic [4:0] cost_code_in;
    logic [12:0] rep_count_in, n;
    logic [15:0] sfr_rdata_out, cost_data_out, m_ctl, m_rep, g16;
    logic [31:0] prod_in, prod_out, p;
    logic [39:0] acc_out, m_acc;
    logic [7:0] m_fl;
    logic saturate_enable_out, product_shift_enable_out, coproc_irq_out;
    logic [12:0] repeat_count_out;
    logic repeat_active_out;
    sfr_req_type sfr_req_in;
    op_event_type op_in;
    int mismatches, n_tests, i, k, g;
    logic [15:0] addrs [5] = '{ADDR_ACC_LOW, ADDR_ACC_HIGH, ADDR_REPEAT,
        ADDR_CONTROL, ADDR_STATUS};
    mac_cpu_model u_cpu (.clk_sys_in(clk_sys_in),
        .sfr_rdata_in(sfr_rdata_out), .cost_data_in(cost_data_out),
        .sfr_req_out(sfr_req_in), .cost_valid_out(cost_valid_in),
        .cost_code_out(cost_code_in));
    mac_accumulator_control_regs u_dut (.clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in), .sfr_req_in(sfr_req_in),
        .sfr_rdata_out(sfr_rdata_out), .cost_valid_in(cost_valid_in),
        .cost_code_in(cost_code_in), .cost_data_out(cost_data_out),
        .op_in(op_in), .prod_in(prod_in), .prod_signed_in(prod_signed_in),
        .prod_out(prod_out), .rep_load_in(rep_load_in),
        .rep_count_in(rep_count_in), .rep_step_in(rep_step_in),
        .rep_end_in(rep_end_in), .acc_out(acc_out),
        .saturate_enable_out(saturate_enable_out),
        .product_shift_enable_out(product_shift_enable_out),
        .coproc_irq_out(coproc_irq_out),
        .repeat_count_out(repeat_count_out),
        .repeat_active_out(repeat_active_out));
    initial
    begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    task automatic chk(input string nm, input logic [39:0] e,
        input logic [39:0] s);
        n_tests++;
        if (s !== e)
        begin
            $display("[ERR] %s expected %h seen %h", nm, e, s);
            mismatches++;
        end
    endtask
    task automatic conclude();
        if (mismatches == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    function automatic logic [15:0] ex(input logic [15:0] a);
        case (a)
            ADDR_ACC_LOW: ex = m_acc[15:0];
            ADDR_ACC_HIGH: ex = m_acc[31:16];
            ADDR_CONTROL: ex = m_ctl;
            ADDR_REPEAT: ex = m_rep;
            ADDR_STATUS: ex = {m_fl, m_acc[39:32]};
            default: ex = 16'h0000;
        endcase
    endfunction
    function automatic logic [15:0] exco(input logic [4:0] c);
        logic t;
        t = m_acc[39:31] != 9'h000 && m_acc[39:31] != 9'h1FF;
        case (c)
            5'h00: exco = ex(ADDR_STATUS);
            5'h01: exco = m_acc[31:16];
            5'h02: exco = t ? (m_acc[39] ? 16'h8000 : 16'h7FFF) : m_acc[31:16];
            5'h04: exco = m_acc[15:0];
            5'h05: exco = m_ctl;
            5'h06: exco = m_rep;
            default: exco = 16'h0000;
        endcase
    endfunction
    task automatic rdchk(input logic [15:0] a);
        logic [15:0] s;
        u_cpu.sfr_rd(a, s);
        chk("sfr_rdata", 40'(ex(a)), 40'(s));
    endtask
    task automatic coall();
        logic [15:0] s;
        for (int c = 0; c < 8; c++)
        begin
            u_cpu.co_rd(5'(c), s);
            chk("cost_data", 40'(exco(5'(c))), 40'(s));
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d,
        input logic [1:0] be);
        logic [15:0] v;
        v = be == BE_WORD ? d : be == BE_LOW ? {8'h00, d[7:0]} :
            {d[15:8], 8'h00};
        u_cpu.sfr_wr(a, d, be);
        case (a)
            ADDR_ACC_LOW: m_acc[15:0] = v;
            ADDR_ACC_HIGH: m_acc[31:16] = v;
            ADDR_CONTROL: m_ctl = v & 16'hFE00;
            ADDR_REPEAT: m_rep = v & 16'h9FFF;
            ADDR_STATUS:
            begin
                m_fl = {m_fl[7] & v[15], 1'b0, v[13:8]};
                m_acc[39:32] = v[7:0];
            end
            default: ;
        endcase
    endtask
    task automatic op(input logic [39:0] r, input logic c, input logic v,
        input logic mm);
        logic [39:0] q;
        logic s;
        @(negedge clk_sys_in);
        op_in = '{done: 1'b1, result: r, carry: c, overflow: v,
            minmax_changed: mm};
        @(negedge clk_sys_in);
        op_in.done = 1'b0;
        s = m_ctl[CW_MS] && r[39:31] != 9'h000 && r[39:31] != 9'h1FF;
        q = !s ? r : (r[39] ? 40'hFF80000000 : 40'h007FFFFFFF);
        m_acc = q;
        m_fl[5:0] = {m_fl[5] | s | mm, q[39:31] != 9'h000 &&
            q[39:31] != 9'h1FF, m_fl[3] | v, c, q == 0, q[39]};
        m_fl[7] |= m_ctl[CW_GIE] & |(m_fl[5:2] & m_ctl[CW_LM:CW_CM]);
        chk("acc", m_acc, acc_out);
        rdchk(ADDR_STATUS);
    endtask
    initial
    begin
        {nrst_in, prod_signed_in, rep_load_in, rep_step_in, rep_end_in} = 0;
        {mismatches, n_tests, prod_in, rep_count_in} = 0;
        op_in = '0;
        repeat (10) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        nrst_in = 1'b1;
        g = $urandom(49323);
        {m_acc, m_ctl, m_rep, m_fl} = {72'h0, 8'h02};
        for (i = 0; i < 5; i++)
            rdchk(addrs[i]);
        rdchk(16'hFE00);
        for (i = 0; i < 30; i++)
        begin
            g16 = 16'($urandom) & (addrs[i % 5] == ADDR_CONTROL ?
                16'h7FFF : 16'hFFFF);
            wr(addrs[i % 5], g16, i < 10 ? BE_WORD : 2'(1 + i % 2));
            rdchk(addrs[i % 5]);
            rdchk(ADDR_STATUS);
            chk("acc", m_acc, acc_out);
        end
        coall();
        wr(ADDR_CONTROL, 16'h0000, BE_WORD);
        op(40'h0, 1'b0, 1'b0, 1'b0);
        for (i = 0; i < 6; i++)
            op({8'($urandom), 32'($urandom)}, 1'($urandom),
                i == 2, 1'b0);
        coall();
        wr(ADDR_CONTROL, 16'h0200, BE_WORD);
        op(40'h0100000000, 1'b0, 1'b0, 1'b0);
        op(40'hF000000000, 1'b0, 1'b0, 1'b0);
        chk("sat_en", 40'h1, 40'(saturate_enable_out));
        coall();
        for (i = 0; i < 12; i++)
        begin
            k = i % 4;
            g = i / 4;
            wr(ADDR_STATUS, 16'h0000, BE_WORD);
            wr(ADDR_CONTROL, 16'(((g > 0) << 15) |
                (16'h0800 << ((k + (g == 1)) % 4))), BE_WORD);
            op(k == 2 ? 40'h0100000000 : 40'h100, k == 0, k == 1, k == 3);
            @(negedge clk_sys_in);
            m_fl[7] = g == 2;
            chk("irq", 40'(g == 2), 40'(coproc_irq_out));
            rdchk(ADDR_STATUS);
        end
        wr(ADDR_STATUS, 16'hFFFF & 16'h7F00, BE_WORD);
        chk("irq", 40'h0, 40'(coproc_irq_out));
        wr(ADDR_STATUS, 16'h0000, BE_WORD);
        for (i = 0; i < 4; i++)
        begin
            wr(ADDR_CONTROL, 16'(i / 2) << CW_MP, BE_WORD);
            chk("mp", 40'(i / 2), 40'(product_shift_enable_out));
            p = $urandom;
            @(negedge clk_sys_in);
            prod_in = p;
            prod_signed_in = i[0];
            @(negedge clk_sys_in);
            chk("prod", 40'(i == 3 ? 32'(p << 1) : p),
                40'(prod_out));
        end
        n = 13'($urandom_range(8191, 1));
        rep_count_in = n;
        rep_load_in = 1'b1;
        @(negedge clk_sys_in);
        rep_load_in = 1'b0;
        rep_step_in = 1'b1;
        chk("rep", {26'h0, 1'b1, n},
            {26'h0, repeat_active_out, repeat_count_out});
        @(negedge clk_sys_in);
        rep_step_in = 1'b0;
        rep_end_in = 1'b1;
        chk("rep_cnt", 40'(n - 1), 40'(repeat_count_out));
        @(negedge clk_sys_in);
        rep_end_in = 1'b0;
        m_rep = {3'b000, n - 13'h1};
        rdchk(ADDR_REPEAT);
        conclude();
    end
endmodule
`default_nettype wire
